//--- pkg/low_addr_mux_defines.vh
// Register map, field positions and reset values of the low address pin mux
`ifndef LOW_ADDR_MUX_DEFINES_VH
`define LOW_ADDR_MUX_DEFINES_VH

`define REG_ADDR_W 4
// Register offsets
`define OFF_FUNC_SEL 4'h0
`define OFF_DIR 4'h1
`define OFF_DATA_OUT 4'h2
`define OFF_PULLUP 4'h3
`define OFF_BUS_CTRL 4'h4
`define OFF_PIN_IN 4'h5
`define OFF_STATUS 4'h6
// Port bit of address line zero
`define PORT_BIT_BASE 8
// Field positions in the bus control register
`define BUS_CTRL_HOLD_BIT 0
// Field positions in the status register
`define STATUS_BUS_ACTIVE_BIT 0
`define STATUS_HOLD_BIT 1
// Reset values (16-bit port view)
`define RST_FUNC_SEL 16'h0000
`define RST_DIR 16'h0000
`define RST_DATA_OUT 16'h0000
`define RST_PULLUP 16'h3f00
`define RST_BUS_CTRL 16'h0000

`endif

//--- verilog/pin_cell.v
// One shared address/port pin: function select, drive and pull-up
`timescale 1ns/1ns
module pin_cell (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Selection and drive
   input wire gpio_sel,
   input wire gpio_dir_out,
   input wire gpio_out,
   input wire addr_bit,
   input wire bus_drive,
   input wire pullup_en,
   // Pin
   output reg pin_out,
   output reg pin_oe,
   output reg pin_pullup
);

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
         pin_pullup <= 1'b1;
      end else begin
         if (gpio_sel) begin
            pin_out <= gpio_out;
            pin_oe <= gpio_dir_out;
         end else begin
            pin_out <= addr_bit;
            pin_oe <= bus_drive;
         end
         pin_pullup <= pullup_en;
      end
   end

endmodule

//--- verilog/low_address_pin_port_mux.v
// Pin sharing of the six low external address lines with port A bits 8..13
`timescale 1ns/1ns
`include "low_addr_mux_defines.vh"
module low_address_pin_port_mux #(
   parameter NPINS = 6
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Register port
   input wire [`REG_ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // External memory interface
   input wire [NPINS-1:0] emi_addr,
   input wire emi_bus_active,
   output reg ext_ctrl_oe,
   // Pins
   input wire [NPINS-1:0] pin_in,
   output wire [NPINS-1:0] pin_out,
   output wire [NPINS-1:0] pin_oe,
   output wire [NPINS-1:0] pin_pullup
);

   localparam LO = `PORT_BIT_BASE;
   localparam HI = `PORT_BIT_BASE + NPINS - 1;
   // Reset words in the 16-bit port view, sliced to the pin field below
   localparam [15:0] RST_FS_WORD = `RST_FUNC_SEL;
   localparam [15:0] RST_DIR_WORD = `RST_DIR;
   localparam [15:0] RST_DO_WORD = `RST_DATA_OUT;
   localparam [15:0] RST_PU_WORD = `RST_PULLUP;
   localparam [15:0] RST_BC_WORD = `RST_BUS_CTRL;

   reg [NPINS-1:0] func_sel;
   reg [NPINS-1:0] dir_out;
   reg [NPINS-1:0] data_out;
   reg [NPINS-1:0] pullup_en;
   reg idle_drive_hold;
   reg [NPINS-1:0] pin_in_q;
   wire bus_drive;
   reg [15:0] next_rdata;

   // Idle bus floats unless software asks for hold
   assign bus_drive = emi_bus_active | idle_drive_hold;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         func_sel <= RST_FS_WORD[HI:LO];
         dir_out <= RST_DIR_WORD[HI:LO];
         data_out <= RST_DO_WORD[HI:LO];
         pullup_en <= RST_PU_WORD[HI:LO];
         idle_drive_hold <= RST_BC_WORD[`BUS_CTRL_HOLD_BIT];
         pin_in_q <= {NPINS{1'b0}};
         ext_ctrl_oe <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         pin_in_q <= pin_in;
         ext_ctrl_oe <= bus_drive;
         reg_rdata <= reg_rd ? next_rdata : 16'h0000;
         if (reg_wr) begin
            case (reg_addr)
               `OFF_FUNC_SEL: func_sel <= reg_wdata[HI:LO];
               `OFF_DIR: dir_out <= reg_wdata[HI:LO];
               `OFF_DATA_OUT: data_out <= reg_wdata[HI:LO];
               `OFF_PULLUP: pullup_en <= reg_wdata[HI:LO];
               `OFF_BUS_CTRL: idle_drive_hold <= reg_wdata[`BUS_CTRL_HOLD_BIT];
               default: ;
            endcase
         end
      end
   end

   // Read mux; port registers place pins at bits 8..13
   always @* begin
      next_rdata = 16'h0000;
      case (reg_addr)
         `OFF_FUNC_SEL: next_rdata[HI:LO] = func_sel;
         `OFF_DIR: next_rdata[HI:LO] = dir_out;
         `OFF_DATA_OUT: next_rdata[HI:LO] = data_out;
         `OFF_PULLUP: next_rdata[HI:LO] = pullup_en;
         `OFF_BUS_CTRL: next_rdata[`BUS_CTRL_HOLD_BIT] = idle_drive_hold;
         `OFF_PIN_IN: next_rdata[HI:LO] = pin_in_q;
         `OFF_STATUS: begin
            next_rdata[`STATUS_BUS_ACTIVE_BIT] = emi_bus_active;
            next_rdata[`STATUS_HOLD_BIT] = bus_drive;
         end
         default: next_rdata = 16'h0000;
      endcase
   end

   genvar i;
   generate
      for (i = 0; i < NPINS; i = i + 1) begin : g_pin
         pin_cell u_cell (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .gpio_sel(func_sel[i]),
            .gpio_dir_out(dir_out[i]),
            .gpio_out(data_out[i]),
            .addr_bit(emi_addr[i]),
            .bus_drive(bus_drive),
            .pullup_en(pullup_en[i]),
            .pin_out(pin_out[i]),
            .pin_oe(pin_oe[i]),
            .pin_pullup(pin_pullup[i])
         );
      end
   endgenerate

endmodule

//--- sim/low_addr_props.sv
// Port checker of the low address pin mux
`timescale 1ns/1ns
module low_addr_props (
   input wire clk_sys, rst_n, reg_wr, reg_rd, emi_bus_active, ext_ctrl_oe,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata, reg_rdata,
   input wire [5:0] pin_oe, pin_pullup);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_RESET: assert property ($past(!rst_n) |-> !pin_oe && &pin_pullup && !ext_ctrl_oe)
      else $error("reset state");
   AST_ADDR: assert property ($past(!rst_n, 2) |-> pin_oe == {6{$past(emi_bus_active)}})
      else $error("addr mode");
   AST_CTRL: assert property ($past(rst_n) && $past(emi_bus_active) |-> ext_ctrl_oe)
      else $error("ctrl oe");
   AST_PULLUP: assert property (reg_wr && reg_addr == 4'h3 |-> ##2
      pin_pullup == $past(reg_wdata[13:8], 2)) else $error("pullup");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   AST_RD_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr) > 4'h6 |->
      reg_rdata == 16'h0000) else $error("unmapped read");
   C_BUS: cover property (emi_bus_active ##2 pin_oe == 6'h3f);
   C_PU: cover property (pin_pullup == 6'h2a);
   C_GPIO: cover property (pin_oe == 6'h15);
endmodule
bind low_address_pin_port_mux low_addr_props chk (.*);

//--- sim/ext_mem_model.sv
// Far-side model of the shared lines
`timescale 1ns/1ns
module ext_mem_model (
   input wire [5:0] pin_out, pin_oe, pin_pullup, ext_drv, ext_oe,
   output wire [5:0] pin_in);
   // A floating line without pull-up shows the inverse of its current pin_out
   assign pin_in = pin_oe & pin_out | ~pin_oe & (ext_oe & ext_drv | ~ext_oe & (pin_pullup | ~pin_out));
endmodule

//--- sim/test_low_address_pin_port_mux.sv
// Directed test of the low address pin mux
`timescale 1ns/1ns
module test_low_address_pin_port_mux;
   reg clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, emi_bus_active = 0;
   reg [3:0] reg_addr = 4'h0;
   reg [15:0] reg_wdata = 16'h0;
   reg [5:0] emi_addr = 6'h0, ext_drv = 6'h0a, ext_oe = 6'h2a;
   wire [15:0] reg_rdata;
   wire [5:0] pin_in, pin_out, pin_oe, pin_pullup;
   wire ext_ctrl_oe;
   integer err_count = 0, compares = 0, cyc = 0;
   low_address_pin_port_mux dut (.*);
   ext_mem_model mem (.*);
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc == 900) begin
      err_count++;
      report_and_stop;
   end
   task chk(input string n, input [15:0] s, e); begin
      compares++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   end endtask
   task wr(input [3:0] a, input [15:0] d); begin
      @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk_sys) reg_wr <= 1'b0;
   end endtask
   task rd(input string n, input [3:0] a, input [15:0] e); begin
      @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys) reg_rd <= 1'b0;
      @(negedge clk_sys) chk(n, reg_rdata, e);
   end endtask
   task pins(input [5:0] oe, o); begin
      repeat (2) @(negedge clk_sys);
      chk("oe", pin_oe, oe);
      chk("out", pin_out & oe, o);
   end endtask
   task report_and_stop; begin
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   end endtask
   initial begin
      repeat (5) @(negedge clk_sys);
      chk("reset", {ext_ctrl_oe, pin_pullup, pin_oe}, 16'h0fc0);
      @(posedge clk_sys) rst_n <= 1'b1;
      rd("pur", 4'h3, 16'h3f00);
      @(posedge clk_sys) {emi_bus_active, emi_addr} <= 7'h6a;
      pins(6'h3f, 6'h2a);
      @(posedge clk_sys) emi_bus_active <= 1'b0;
      pins(6'h0, 6'h0);
      chk("ctrl", ext_ctrl_oe, 16'h0000);
      wr(4'h4, 16'h1);
      pins(6'h3f, 6'h2a);
      chk("ctrl", ext_ctrl_oe, 16'h0001);
      wr(4'h0, 16'h3f00);
      wr(4'h1, 16'h1500);
      wr(4'h2, 16'h3f00);
      pins(6'h15, 6'h15);
      rd("pin", 4'h5, 16'h1f00);
      rd("dir", 4'h1, 16'h1500);
      wr(4'h3, 16'h2a00);
      rd("pur", 4'h3, 16'h2a00);
      chk("pu", pin_pullup, 6'h2a);
      rd("bad", 4'hf, 16'h0);
      rd("stat", 4'h6, 16'h0002);
      // Second reset in mid-run: selection must fall back to address function
      @(posedge clk_sys) rst_n <= 1'b0;
      @(posedge clk_sys) rst_n <= 1'b1;
      rd("fsel", 4'h0, 16'h0000);
      chk("reset2", {ext_ctrl_oe, pin_pullup, pin_oe}, 16'h0fc0);
      report_and_stop;
   end
endmodule
